// ---- core/ttm_transport.sv ----
// Top of the tape transport motion and setup interface.
`timescale 1ns/100ps
module ttm_transport
	import ttm_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         unit_select,
	input  wire ttm_cmd_s     cmd,
	input  wire ttm_panel_s   panel,
	output logic              iface_enable,
	output logic              drive_fwd,
	output logic              drive_rev,
	output logic [SPEED_W-1:0] capstan_speed,
	output logic              tape_moving,
	output logic              write_mode,
	output logic              high_density,
	output logic              rewrite_active
);

	// ------------------------------------------------------------
	// Qualification
	// ------------------------------------------------------------
	logic        armed;
	logic        connected;
	logic        go_ok;
	logic        fwd_req;
	logic        rev_req;
	logic        fwd_prev_reg;
	logic        rev_prev_reg;
	logic        fwd_edge;
	logic        rev_edge;
	logic        rev_block_reg;
	logic        rev_block_next;
	ttm_motion_e state_reg;
	ttm_motion_e state_next;
	logic        run;
	logic        halt_now;
	logic [SPEED_W-1:0] speed;
	logic        moving;
	logic        wm;
	logic        hd;
	logic        rw;
	logic        mode_sample;

	assign armed     = panel.loaded && panel.online;
	assign connected = armed && unit_select;
	assign go_ok     = connected && panel.ready;
	assign fwd_req   = go_ok && cmd.forward && !cmd.reverse;
	assign rev_req   = go_ok && cmd.reverse && !cmd.forward;
	assign fwd_edge  = connected && cmd.forward && !fwd_prev_reg;
	assign rev_edge  = connected && cmd.reverse && !rev_prev_reg;
	assign mode_sample = fwd_edge || rev_edge;

	// A reverse level that met the load point stays refused until it drops.
	assign rev_block_next =
		!cmd.reverse ? 1'b0 :
		(rev_edge && panel.load_point) ? 1'b1 :
		(state_reg == TTM_REV && panel.load_point) ? 1'b1 :
		rev_block_reg;

	// ------------------------------------------------------------
	// Motion state machine
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TTM_IDLE: begin
				if (fwd_req)
					state_next = TTM_FWD;
				else if (rev_req && !rev_block_next && !panel.load_point)
					state_next = TTM_REV;
			end
			TTM_FWD: begin
				if (!fwd_req)
					state_next = TTM_STOPPING;
			end
			TTM_REV: begin
				if (!rev_req || panel.load_point)
					state_next = TTM_IDLE;
			end
			TTM_STOPPING: begin
				if (!moving)
					state_next = TTM_IDLE;
				else if (fwd_req)
					state_next = TTM_FWD;
			end
			default: state_next = TTM_IDLE;
		endcase
	end

	assign run      = (state_next == TTM_FWD) || (state_next == TTM_REV);
	assign halt_now = (state_reg == TTM_REV) && (state_next == TTM_IDLE);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg     <= TTM_IDLE;
			fwd_prev_reg  <= 1'b0;
			rev_prev_reg  <= 1'b0;
			rev_block_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			fwd_prev_reg  <= connected && cmd.forward;
			rev_prev_reg  <= connected && cmd.reverse;
			rev_block_reg <= rev_block_next;
		end
	end

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	ttm_ramp u_ramp (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (run),
		.halt_now (halt_now),
		.speed    (speed),
		.moving   (moving)
	);

	ttm_setup u_setup (
		.core_clk              (core_clk),
		.rst                   (rst),
		.sample                (mode_sample),
		.connected             (connected),
		.write_status_set      (cmd.write_status_set),
		.density_choose        (cmd.density_choose),
		.record_rewrite_enable (cmd.record_rewrite_enable),
		.remote_density        (panel.remote_density),
		.dual_density          (panel.dual_density),
		.write_mode            (wm),
		.high_density          (hd),
		.rewrite_active        (rw)
	);

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			iface_enable   <= 1'b0;
			drive_fwd      <= 1'b0;
			drive_rev      <= 1'b0;
			capstan_speed  <= SPEED_ZERO;
			tape_moving    <= 1'b0;
			write_mode     <= RW_RESET;
			high_density   <= 1'b0;
			rewrite_active <= 1'b0;
		end else begin
			iface_enable   <= connected;
			drive_fwd      <= (state_reg == TTM_FWD) ||
			                  (state_reg == TTM_STOPPING);
			drive_rev      <= (state_reg == TTM_REV);
			capstan_speed  <= speed;
			tape_moving    <= moving;
			write_mode     <= wm;
			high_density   <= hd;
			rewrite_active <= rw;
		end
	end

endmodule : ttm_transport

// ---- core/ttm_pkg.sv ----
// Package of constants and types for the tape transport motion setup block.
package ttm_pkg;

	// ------------------------------------------------------------
	// Speed ramp, write mode reset value and shared types
	// ------------------------------------------------------------
	localparam int         SPEED_W       = 8;
	localparam logic [7:0] SPEED_FULL    = 8'hFF;
	localparam logic [7:0] SPEED_ZERO    = 8'h00;
	localparam logic [7:0] SPEED_STEP    = 8'h01;
	localparam int         RAMP_TICK_NS  = 1000;
	localparam int         CLK_PERIOD_NS = 8;
	localparam int         RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;
	localparam int         TICK_W        = 8;
	localparam logic       RW_RESET      = 1'b0;

	typedef enum logic [1:0] {
		TTM_IDLE,
		TTM_FWD,
		TTM_REV,
		TTM_STOPPING
	} ttm_motion_e;

	typedef struct packed {
		logic forward;
		logic reverse;
		logic write_status_set;
		logic density_choose;
		logic record_rewrite_enable;
	} ttm_cmd_s;

	typedef struct packed {
		logic online;
		logic loaded;
		logic ready;
		logic load_point;
		logic remote_density;
		logic dual_density;
	} ttm_panel_s;

endpackage : ttm_pkg

// ---- core/ttm_ramp.sv ----
// Speed ramp generator for the tape capstan.
`timescale 1ns/100ps
module ttm_ramp
	import ttm_pkg::*;
(
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               run,
	input  wire logic               halt_now,
	output logic [SPEED_W-1:0]      speed,
	output logic                    moving
);

	// ------------------------------------------------------------
	// Tick counter and speed accumulator
	// ------------------------------------------------------------
	logic [TICK_W-1:0]  tick_reg;
	logic [TICK_W-1:0]  tick_next;
	logic               tick;
	logic [SPEED_W-1:0] speed_reg;
	logic [SPEED_W-1:0] speed_next;

	assign tick      = (tick_reg == TICK_W'(RAMP_TICK_CYC - 1));
	assign tick_next = tick ? '0 : tick_reg + TICK_W'(1);
	assign speed_next =
		halt_now ? SPEED_ZERO :
		(run && speed_reg != SPEED_FULL && tick) ? speed_reg + SPEED_STEP :
		(!run && speed_reg != SPEED_ZERO && tick) ? speed_reg - SPEED_STEP :
		speed_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tick_reg  <= '0;
			speed_reg <= SPEED_ZERO;
		end else begin
			tick_reg  <= tick_next;
			speed_reg <= speed_next;
		end
	end

	assign speed  = speed_reg;
	assign moving = (speed_reg != SPEED_ZERO);

endmodule : ttm_ramp

// ---- core/ttm_setup.sv ----
// Mode latch for read or write state, density and overwrite.
`timescale 1ns/100ps
module ttm_setup
	import ttm_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic sample,
	input  wire logic connected,
	input  wire logic write_status_set,
	input  wire logic density_choose,
	input  wire logic record_rewrite_enable,
	input  wire logic remote_density,
	input  wire logic dual_density,
	output logic      write_mode,
	output logic      high_density,
	output logic      rewrite_active
);

	logic write_reg;
	logic hd_reg;
	logic ovw_reg;
	logic hd_next;
	logic ovw_next;

	assign hd_next  = dual_density && remote_density && density_choose;
	assign ovw_next = record_rewrite_enable && write_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			write_reg <= RW_RESET;
			hd_reg    <= 1'b0;
			ovw_reg   <= 1'b0;
		end else begin
			if (sample)
				write_reg <= write_status_set;
			if (connected)
				hd_reg <= hd_next;
			ovw_reg <= connected && ovw_next;
		end
	end

	assign write_mode     = write_reg;
	assign high_density   = hd_reg;
	assign rewrite_active = ovw_reg;

endmodule : ttm_setup

// ---- tb/ttm_props.sv ----
// Checker of the transport motion and setup outputs.
`timescale 1ns/100ps
module ttm_props
	import ttm_pkg::*;
(
	input wire logic		core_clk,
	input wire logic		rst,
	input wire logic		unit_select,
	input wire ttm_cmd_s		cmd,
	input wire ttm_panel_s		panel,
	input wire logic		iface_enable,
	input wire logic		drive_fwd,
	input wire logic		drive_rev,
	input wire logic [SPEED_W-1:0]	capstan_speed,
	input wire logic		tape_moving,
	input wire logic		write_mode,
	input wire logic		high_density,
	input wire logic		rewrite_active
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence fwd_req;
		(cmd.forward && !cmd.reverse && panel.ready && iface_enable)[*2];
	endsequence
	sequence idle_3;
		(!cmd.forward && !cmd.reverse)[*3];
	endsequence
	iface_gate_a: assert property (!$past(rst) |-> iface_enable ==
		$past(panel.loaded && panel.online && unit_select)) else $error("iface");
	fwd_drive_a: assert property (fwd_req |=> drive_fwd)
		else $error("fwd");
	ramp_down_a: assert property (idle_3 |->
		capstan_speed <= $past(capstan_speed)) else $error("ramp");
	ramp_pace_a: assert property (drive_fwd && $changed(capstan_speed) |=>
		$stable(capstan_speed)) else $error("pace");
	rev_stop_a: assert property (drive_rev && panel.load_point |->
		##[1:3] (!drive_rev && !tape_moving)) else $error("lp stop");
	rev_block_a: assert property ((panel.load_point && !drive_rev)[*2] |=>
		!drive_rev) else $error("lp block");
	hold_mode_a: assert property (!iface_enable[*2] |-> $stable(write_mode))
		else $error("mode");
	dens_pick_a: assert property ((iface_enable && panel.remote_density &&
		panel.dual_density && $stable(cmd.density_choose))[*3] |->
		high_density == cmd.density_choose) else $error("density");
	rw_on_a: assert property ((write_mode && iface_enable &&
		cmd.record_rewrite_enable)[*3] |-> rewrite_active) else $error("ovw");
endmodule : ttm_props
bind ttm_transport ttm_props i_props (.*);

// ---- tb/ttm_ctrl_model.sv ----
// Controller model that drives select and motion levels.
`timescale 1ns/100ps
module ttm_ctrl_model
	import ttm_pkg::*;
(
	input  wire logic	core_clk,
	input  wire logic	rst,
	input  wire logic	sel_req,
	input  wire ttm_cmd_s	req,
	input  wire logic	tape_moving,
	output logic		unit_select = 1'b0,
	output ttm_cmd_s	cmd = '0
);
	ttm_cmd_s	cmd_next;
	always_comb begin
		cmd_next = req;
		cmd_next.forward = req.forward && !req.reverse && !cmd.reverse;
		cmd_next.reverse = req.reverse && !req.forward && !cmd.forward
			&& (cmd.reverse || !tape_moving);
	end
	always @(negedge core_clk or posedge rst) begin
		if (rst) begin
			unit_select <= 1'b0;
			cmd <= '0;
		end else begin
			cmd <= cmd_next;
			unit_select <= sel_req || tape_moving;
		end
	end
endmodule : ttm_ctrl_model

// ---- tb/tb_top.sv ----
// Self-checking bench of the transport motion and setup block.
`timescale 1ns/100ps
module tb_top
	import ttm_pkg::*;
;
	logic			core_clk = 1'b0;
	logic			rst = 1'b1;
	logic			sel_req = 1'b0;
	ttm_cmd_s		req = '0;
	ttm_panel_s		panel = '0;
	ttm_cmd_s		cmd;
	logic			unit_select, iface_enable, drive_fwd, drive_rev;
	logic			tape_moving, write_mode, high_density, rewrite_active;
	logic [SPEED_W-1:0]	capstan_speed;
	int			fails = 0;
	int			checks_done = 0;
	int			k;
	always #4 core_clk = ~core_clk;
	ttm_ctrl_model i_ctrl (.core_clk(core_clk), .rst(rst), .sel_req(sel_req),
		.req(req), .tape_moving(tape_moving), .unit_select(unit_select),
		.cmd(cmd));
	ttm_transport i_dut (.core_clk(core_clk), .rst(rst),
		.unit_select(unit_select), .cmd(cmd), .panel(panel),
		.iface_enable(iface_enable), .drive_fwd(drive_fwd),
		.drive_rev(drive_rev), .capstan_speed(capstan_speed),
		.tape_moving(tape_moving), .write_mode(write_mode),
		.high_density(high_density), .rewrite_active(rewrite_active));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task automatic bound();
		if (k >= 2000) begin
			fails++;
			print_verdict();
		end
	endtask : bound
	task automatic t_select();
		panel.online <= 1'b1;
		sel_req <= 1'b1;
		cyc(4);
		check(8'(iface_enable), 8'h00);
		panel.loaded <= 1'b1;
		cyc(3);
		check(8'(iface_enable), 8'h01);
		sel_req <= 1'b0;
		cyc(3);
		check(8'(iface_enable), 8'h00);
	endtask : t_select
	task automatic t_forward();
		sel_req <= 1'b1;
		panel <= 6'h3B;
		cyc(3);
		req <= 5'h16;
		for (k = 0; k < 2000 && capstan_speed !== 8'h02; k++) cyc(1);
		bound();
		check(8'(drive_fwd), 8'h01);
		check(8'(write_mode), 8'h01);
		check(8'(high_density), 8'h01);
		req <= 5'h05;
		cyc(5);
		check(8'(rewrite_active), 8'h01);
		check(8'(high_density), 8'h00);
		for (k = 0; k < 2000 && tape_moving !== 1'b0; k++) cyc(1);
		bound();
		cyc(3);
		check(capstan_speed, 8'h00);
		check(8'(drive_fwd), 8'h00);
		sel_req <= 1'b0;
		req <= 5'h00;
		cyc(4);
		check(8'(write_mode), 8'h01);
	endtask : t_forward
	task automatic t_reverse();
		sel_req <= 1'b1;
		req <= 5'h01;
		cyc(3);
		req <= 5'h09;
		for (k = 0; k < 2000 && drive_rev !== 1'b1; k++) cyc(1);
		bound();
		cyc(200);
		check(8'(write_mode), 8'h00);
		check(8'(rewrite_active), 8'h00);
		check(8'(tape_moving), 8'h01);
		panel <= 6'h3F;
		cyc(4);
		check(8'(drive_rev), 8'h00);
		check(8'(tape_moving), 8'h00);
		req <= 5'h00;
		cyc(3);
		req <= 5'h08;
		cyc(6);
		check(8'(drive_rev), 8'h00);
		req <= 5'h02;
		cyc(4);
		check(8'(high_density), 8'h01);
		panel <= 6'h3D;
		cyc(4);
		check(8'(high_density), 8'h00);
	endtask : t_reverse
	initial begin
		cyc(5);
		rst <= 1'b0;
		cyc(2);
		t_select();
		t_forward();
		t_reverse();
		print_verdict();
	end
endmodule : tb_top
